// [rtl/lpi_defines.vh]
// constants and field layout of the led port pwm intensity engine
//----------------------------------------------------------------------
// What this block does
//----------------------------------------------------------------------
// What this block does
// R1: a zero master nibble makes every output static, ignoring all else.
// R2: nonzero master and global flag clear take per-output nibbles.
// R3: nibble 0xf is static at the phase level, 0x0 to 0xe is pwm.
// R4: global flag set with nonzero master uses only register 0x0e.
// R5: the host writes differing per-output values to mix static and pwm.
// R6: level bit 0 gives low time (n+1)/16 and high time (15-n)/16.
// R7: level bit 1 inverts that ratio and 0xf gives static high-z.
// R8: level bit 0 with nibble 0xf holds the output low continuously.
// R9: with blink on, the active phase level bit sets pwm polarity.
// R10: the aux output nibble doubles as the shared global intensity.
// R11: global mode applies to every output, never to a subset.
// R12: master and shared nibbles form an 8-bit 240-step control.
// R13: a period is 240 steps, 15 timeslots of 16 cycles each.
// R14: a zero master nibble stops the pwm step timer.
// R15: blink off uses phase-0 bits, blink on picks phase by flip flag.
// R16: a 16/16 setting skips timeslot gating and gives a static level.
// R17: new intensity values take effect at the next period boundary, or at once while stopped.
`ifndef LPI_DEFINES_VH
`define LPI_DEFINES_VH
`define LPI_ADDR_MASTER_AUX  8'h0e
`define LPI_ADDR_INTENS_0    8'h10
`define LPI_ADDR_INTENS_7    8'h17
`define LPI_MASTER_MSB       7
`define LPI_MASTER_LSB       4
`define LPI_SHARED_MSB       3
`define LPI_SHARED_LSB       0
`define LPI_RESET_BYTE       8'h00
`define LPI_STATIC_NIBBLE    4'hf
`define LPI_CYCLES_PER_SLOT  4'hf
`define LPI_SLOTS_PER_PERIOD 4'he
`define LPI_OSC_HZ           32768
`define LPI_CLOCK_HZ         50000000
`define LPI_STEP_DIV         (`LPI_CLOCK_HZ / `LPI_OSC_HZ)
`endif

// [rtl/lpi_reg_mem.v]
// small register memory for the eight per-output intensity bytes
`timescale 1ns/1ns
`include "lpi_defines.vh"
module lpi_reg_mem (
	input  wire       clock,
	input  wire       reset_n,
	input  wire       wr_en,
	input  wire [2:0] wr_addr,
	input  wire [7:0] wr_data,
	input  wire [2:0] rd_addr,
	output reg  [7:0] rd_data,
	output wire [63:0] all_data
);
	reg [7:0] mem [0:7];
	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : g_ent
			always @(posedge clock or negedge reset_n) begin
				if (!reset_n)
					mem[g] <= `LPI_RESET_BYTE;
				else if (wr_en && wr_addr == g)
					mem[g] <= wr_data;
			end
			assign all_data[g*8+7:g*8] = mem[g];
		end
	endgenerate
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			rd_data <= `LPI_RESET_BYTE;
		else
			rd_data <= mem[rd_addr];
	end
endmodule // lpi_reg_mem

// [rtl/lpi_pwm_engine.v]
// pwm intensity engine for sixteen port outputs and the aux output
`timescale 1ns/1ns
`include "lpi_defines.vh"
module lpi_pwm_engine #(
	parameter STEP_DIV = `LPI_STEP_DIV
) (
	input  wire        clock,
	input  wire        reset_n,
	input  wire        reg_wr,
	input  wire [7:0]  reg_addr,
	input  wire [7:0]  reg_wdata,
	output reg  [7:0]  reg_rdata,
	input  wire        global_select,
	input  wire        blink_enable,
	input  wire        blink_flip,
	input  wire [15:0] phase_level_bits_0,
	input  wire [15:0] phase_level_bits_1,
	input  wire        aux_level_0,
	input  wire        aux_level_1,
	output reg  [15:0] port_pins_oe,
	output reg         aux_output_oe,
	output wire [15:0] port_pins_out,
	output wire        aux_output_out,
	output wire        pwm_running
);
	//------------------------------------------------------------
	// registers
	//------------------------------------------------------------
	reg  [7:0]  master_aux_intensity;
	wire [63:0] intens_all;
	wire [7:0]  mem_rdata;
	wire        mem_sel;
	reg         mem_sel_q;
	reg  [7:0]  reg_addr_q;
	assign mem_sel = (reg_addr >= `LPI_ADDR_INTENS_0) &&
		(reg_addr <= `LPI_ADDR_INTENS_7);
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			master_aux_intensity <= `LPI_RESET_BYTE;
		else if (reg_wr && reg_addr == `LPI_ADDR_MASTER_AUX)
			master_aux_intensity <= reg_wdata;
	end
	lpi_reg_mem u_mem (
		.clock    (clock),
		.reset_n  (reset_n),
		.wr_en    (reg_wr && mem_sel),
		.wr_addr  (reg_addr[2:0]),
		.wr_data  (reg_wdata),
		.rd_addr  (reg_addr[2:0]),
		.rd_data  (mem_rdata),
		.all_data (intens_all)
	);
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			mem_sel_q  <= 1'b0;
			reg_addr_q <= 8'h00;
		end else begin
			mem_sel_q  <= mem_sel;
			reg_addr_q <= reg_addr;
		end
	end
	// read data one cycle after the address, unmapped reads zero
	always @* begin
		if (mem_sel_q)
			reg_rdata = mem_rdata;
		else if (reg_addr_q == `LPI_ADDR_MASTER_AUX)
			reg_rdata = master_aux_intensity;
		else
			reg_rdata = 8'h00;
	end
	//------------------------------------------------------------
	// step timer and period counters
	//------------------------------------------------------------
	reg  [15:0] div_cnt;
	reg  [3:0]  cyc_cnt;
	reg  [3:0]  slot_cnt;
	reg  [7:0]  act_master_aux;
	reg  [63:0] act_intens;
	reg         act_global;
	wire [3:0]  act_master;
	wire        step;
	wire        period_end;
	assign act_master = act_master_aux[`LPI_MASTER_MSB:`LPI_MASTER_LSB];
	// timer halts while the live master nibble is zero
	assign pwm_running = |master_aux_intensity[`LPI_MASTER_MSB:
		`LPI_MASTER_LSB]; // [R14]
	assign step = pwm_running && (div_cnt == STEP_DIV - 1);
	assign period_end = step && cyc_cnt == `LPI_CYCLES_PER_SLOT &&
		slot_cnt == `LPI_SLOTS_PER_PERIOD; // [R13]
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			div_cnt  <= 16'h0000;
			cyc_cnt  <= 4'h0;
			slot_cnt <= 4'h0;
		end else if (!pwm_running) begin
			div_cnt  <= 16'h0000; // [R14]
			cyc_cnt  <= 4'h0;
			slot_cnt <= 4'h0;
		end else if (step) begin
			div_cnt <= 16'h0000;
			cyc_cnt <= cyc_cnt + 4'h1;
			if (cyc_cnt == `LPI_CYCLES_PER_SLOT)
				slot_cnt <= (slot_cnt == `LPI_SLOTS_PER_PERIOD) ?
					4'h0 : slot_cnt + 4'h1; // [R13]
		end else begin
			div_cnt <= div_cnt + 16'h0001;
		end
	end
	// settings load at period boundary, or at once while stopped
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			act_master_aux <= `LPI_RESET_BYTE;
			act_intens     <= 64'h0;
			act_global     <= 1'b0;
		end else if (period_end || !pwm_running ||
			act_master == 4'h0) begin
			act_master_aux <= master_aux_intensity; // [R17]
			act_intens     <= intens_all;
			act_global     <= global_select;
		end
	end
	//------------------------------------------------------------
	// per-output duty generation
	//------------------------------------------------------------
	wire [3:0]  shared_intensity_nibble;
	wire        slot_on;
	wire [16:0] level;
	wire [16:0] pin_hiz;
	assign shared_intensity_nibble =
		act_master_aux[`LPI_SHARED_MSB:`LPI_SHARED_LSB]; // [R10]
	// master gates the first n slots of each period
	assign slot_on = slot_cnt < act_master; // [R13]
	// phase select: blink off always phase 0
	assign level = (blink_enable && blink_flip) ?
		{aux_level_1, phase_level_bits_1} :
		{aux_level_0, phase_level_bits_0}; // [R15] [R9]
	genvar i;
	generate
		for (i = 0; i < 17; i = i + 1) begin : g_out
			wire [3:0] nib;
			wire       low_win;
			wire       active_low;
			if (i == 16) begin : g_aux
				assign nib = shared_intensity_nibble; // [R10]
			end else begin : g_port
				// global mode covers every port alike
				assign nib = act_global ? shared_intensity_nibble :
					act_intens[(i/2)*8+(i%2)*4+3:(i/2)*8+(i%2)*4];
				// [R2] [R4] [R11] [R12]
			end
			// low for the first n+1 cycles of the slot
			assign low_win = cyc_cnt <= nib; // [R6]
			assign active_low = level[i] ? !low_win : low_win; // [R7]
			assign pin_hiz[i] =
				(act_master == 4'h0) ? level[i] : // [R1] [R14]
				(nib == `LPI_STATIC_NIBBLE) ? level[i] : // [R3] [R8] [R16]
				!slot_on ? 1'b1 :
				!active_low; // [R6] [R7] [R9]
		end
	endgenerate
	// open-drain: output data always low, enable sinks the pin
	assign port_pins_out  = 16'h0000;
	assign aux_output_out = 1'b0;
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			port_pins_oe  <= 16'h0000;
			aux_output_oe <= 1'b0;
		end else begin
			port_pins_oe  <= ~pin_hiz[15:0];
			aux_output_oe <= ~pin_hiz[16];
		end
	end
endmodule // lpi_pwm_engine

// [tb/lpi_load.sv]
// pulled-up loads on the open-drain port pins
`timescale 1ns/1ns
module lpi_load (
	input  wire [15:0] oe,
	input  wire [15:0] dout,
	output wire [15:0] pin
);
	// a released pin floats up to the pull-up
	assign pin = (oe & dout) | ~oe;
endmodule // lpi_load

// [tb/lpi_chk.sv]
// port assertions of the pwm intensity engine
`timescale 1ns/1ns
module lpi_chk (
	input wire        clock,
	input wire        reset_n,
	input wire        reg_wr,
	input wire [7:0]  reg_addr,
	input wire [7:0]  reg_wdata,
	input wire [7:0]  reg_rdata,
	input wire        blink_enable,
	input wire        blink_flip,
	input wire [15:0] phase_level_bits_0,
	input wire [15:0] phase_level_bits_1,
	input wire [15:0] port_pins_oe,
	input wire [15:0] port_pins_out,
	input wire        aux_level_0,
	input wire        aux_level_1,
	input wire        aux_output_oe,
	input wire        aux_output_out,
	input wire        pwm_running
);
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	wire        mapped  = reg_addr == 8'h0e || reg_addr[7:3] == 5'h02;
	wire        sel1    = blink_enable && blink_flip;
	wire [15:0] act_lvl = sel1 ? phase_level_bits_1 : phase_level_bits_0;
	wire        aux_lvl = sel1 ? aux_level_1 : aux_level_0;
	sequence s_mwr;
		reg_wr && reg_addr == 8'h0e;
	endsequence
	// memory read in the write cycle still sees the old byte
	sequence s_wr_hold;
		reg_wr && mapped ##1 !reg_wr && $stable(reg_addr);
	endsequence
	// two stopped cycles so the active copy has caught up
	sequence s_idle;
		!pwm_running ##1 !pwm_running;
	endsequence
	property p_run;
		s_mwr ##0 reg_wdata[7:4] != 4'h0 |=> pwm_running;
	endproperty
	a_run: assert property (p_run) else $error("pwm not started");
	property p_stop;
		s_mwr ##0 reg_wdata[7:4] == 4'h0 |=> !pwm_running;
	endproperty
	a_stop: assert property (p_stop) else $error("pwm not stopped");
	property p_hold;
		!(reg_wr && reg_addr == 8'h0e) |=> $stable(pwm_running);
	endproperty
	a_hold: assert property (p_hold) else $error("pwm state moved");
	property p_rd;
		s_wr_hold |=> reg_rdata == $past(reg_wdata, 2);
	endproperty
	a_rd: assert property (p_rd) else $error("readback wrong");
	property p_unm;
		reg_wr && !mapped |=> reg_rdata == 8'h00;
	endproperty
	a_unm: assert property (p_unm) else $error("unmapped not zero");
	property p_rdst;
		!reg_wr && !$past(reg_wr) && $stable(reg_addr) |=>
			$stable(reg_rdata);
	endproperty
	a_rdst: assert property (p_rdst) else $error("rdata moved");
	property p_od;
		port_pins_out == 16'h0000 && aux_output_out == 1'b0;
	endproperty
	a_od: assert property (p_od) else $error("pin data driven");
	property p_static;
		s_idle |=> port_pins_oe == ~$past(act_lvl);
	endproperty
	a_static: assert property (p_static) else $error("not static");
	property p_aux_static;
		s_idle |=> aux_output_oe == ~$past(aux_lvl);
	endproperty
	a_aux_static: assert property (p_aux_static) else $error("aux not static");
endmodule // lpi_chk
bind lpi_pwm_engine lpi_chk lpi_chk_i (.clock, .reset_n, .reg_wr, .reg_addr,
	.reg_wdata, .reg_rdata, .blink_enable, .blink_flip, .phase_level_bits_0,
	.phase_level_bits_1, .port_pins_oe, .port_pins_out, .aux_level_0,
	.aux_level_1, .aux_output_oe, .aux_output_out, .pwm_running);

// [tb/tb_lpi_pwm_engine.sv]
// testbench of the pwm intensity engine
`timescale 1ns/1ns
module tb_lpi_pwm_engine;
	reg         clock = 0, reset_n = 0, reg_wr = 0;
	reg  [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00;
	reg         global_select = 0, blink_enable = 0, blink_flip = 0;
	reg  [15:0] phase_level_bits_0 = 16'h00ff, phase_level_bits_1 = 16'h0;
	reg         aux_level_0 = 0, aux_level_1 = 1;
	wire [7:0]  reg_rdata;
	wire [15:0] port_pins_oe, port_pins_out, pins;
	wire        aux_output_oe, aux_output_out, pwm_running;
	integer     fails = 0, n_tests = 0, cyc = 0, k;
	always #10 clock = ~clock;
	lpi_pwm_engine #(.STEP_DIV(2)) lpi_pwm_engine_i (.clock, .reset_n,
		.reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .global_select,
		.blink_enable, .blink_flip, .phase_level_bits_0, .phase_level_bits_1,
		.aux_level_0, .aux_level_1, .port_pins_oe, .aux_output_oe,
		.port_pins_out, .aux_output_out, .pwm_running);
	lpi_load lpi_load_i (.oe(port_pins_oe), .dout(port_pins_out), .pin(pins));
	task finish_test;
		begin
			$display("checks %0d fails %0d", n_tests, fails);
			if (fails == 0 && n_tests > 0)
				$display("ALL CHECKS OK");
			else
				$display("CHECKS NOT OK");
			$finish;
		end
	endtask
	task chk(input string nm, input [15:0] e, input [15:0] g);
		begin
			n_tests = n_tests + 1;
			if (g !== e) begin
				fails = fails + 1;
				$display("FAIL %s exp %h got %h", nm, e, g);
			end
		end
	endtask
	task wr(input [7:0] a, input [7:0] d);
		begin
			@(posedge clock);
			reg_wr <= 1;
			reg_addr <= a;
			reg_wdata <= d;
			@(posedge clock);
			reg_wr <= 0;
		end
	endtask
	task rd(input [7:0] a, input [7:0] e);
		begin
			@(posedge clock);
			reg_addr <= a;
			@(posedge clock);
			#1 chk("rdata", {8'h00, e}, {8'h00, reg_rdata});
		end
	endtask
	// one period settles the new setting, the next is counted;
	// two spare cycles cover the load edge and the oe flop
	task duty(input [7:0] m, i, input g, b, lv, input [15:0] e, ea);
		integer c, ca;
		begin
			wr(8'h0e, m);
			wr(8'h10, i);
			global_select <= g;
			blink_enable <= b;
			blink_flip <= b;
			phase_level_bits_0 <= {16{lv ^ b}};
			phase_level_bits_1 <= {16{lv}};
			repeat (482) @(posedge clock);
			c = 0;
			ca = 0;
			repeat (480) begin
				@(negedge clock);
				if (pins[0] === 1'b0) c = c + 1;
				if (aux_output_oe === 1'b1) ca = ca + 1;
			end
			chk("low count", e, c[15:0]);
			chk("aux low count", ea, ca[15:0]);
		end
	endtask
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 12000) begin
			fails = fails + 1;
			finish_test;
		end
	end
	initial begin
		repeat (5) @(posedge clock);
		reset_n <= 1;
		repeat (2) @(posedge clock);
		#1 chk("oe", 16'hff00, port_pins_oe);
		chk("aux oe", 16'h0001, {15'h0000, aux_output_oe});
		chk("aux out", 16'h0000, {15'h0000, aux_output_out});
		wr(8'h0e, 8'h0f);
		rd(8'h0e, 8'h0f);
		for (k = 0; k < 8; k = k + 1)
			wr(8'h10 + k[7:0], 8'ha0 + k[7:0]);
		for (k = 0; k < 8; k = k + 1)
			rd(8'h10 + k[7:0], 8'ha0 + k[7:0]);
		wr(8'h20, 8'h55);
		rd(8'h20, 8'h00);
		chk("oe", 16'hff00, port_pins_oe);
		duty(8'hf3, 8'h00, 0, 0, 0, 30, 120);
		duty(8'hf3, 8'h0e, 0, 0, 0, 450, 120);
		duty(8'h50, 8'h02, 0, 0, 1, 130, 10);
		duty(8'h50, 8'h0f, 0, 0, 0, 480, 10);
		duty(8'h50, 8'h0f, 0, 0, 1, 0, 10);
		duty(8'h34, 8'h0f, 1, 0, 0, 30, 30);
		duty(8'h72, 8'h05, 0, 1, 1, 140, 182);
		duty(8'h0a, 8'h02, 0, 1, 0, 480, 0);
		finish_test;
	end
endmodule // tb_lpi_pwm_engine
